// >>> design/dpr_ctrl.sv
// Notes on behaviour
// (R01) word: command nibble, address nibble, 16-bit data
// (R02) execute only after all three bytes
// (R03) 0100b powers down addressed channels only
// (R04) 0101b powers down all channels and reference
// (R05) 0111b selects external reference, reference off
// (R06) power-down data word sent but ignored
// (R07) power-down never alters input or dac registers
// (R08) update or load pin wakes a channel
// (R09) some channel up before: 12us wake delay
// (R10) all down with reference: 14us delay
// (R11) reference off by 0111b: only 0110b restores
// (R12) reference off by 0101b: 0110b or wake
// (R13) internal reference at reset, 0110b selects it
// (R14) powered-down output high-z with pulldown
// (R15) keep power-down flags and reference-off cause
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "dpr_cfg.svh"
module dpr_ctrl (
  input  wire logic             ref_clk,          // 20 MHz clock
  input  wire logic             nrst,             // async reset, low
  input  wire logic             wb_cyc_i,         // bus cycle
  input  wire logic             wb_stb_i,         // bus strobe
  input  wire logic             wb_we_i,          // write enable
  input  wire logic [7:0]       wb_adr_i,         // byte address
  input  wire logic [3:0]       wb_sel_i,         // byte lanes
  input  wire logic [31:0]      wb_dat_i,         // write data
  output logic      [31:0]      wb_dat_o,         // read data
  output logic                  wb_ack_o,         // acknowledge
  input  wire logic             async_load_pin_n, // load pin, low
  output logic      [127:0]     dac_code_o,       // dac codes, ch0 low
  output dpr_pkg::dpr_mask_type out_hiz,          // output off, pulled
  output logic                  int_ref_on,       // internal ref on
  output logic                  ref_ext_mode,     // external ref mode
  output logic                  bias_on,          // main bias enabled
  output logic                  settle_busy       // wake delay running
);
  import dpr_pkg::*;

  dpr_link_if lnk();  // links to assembler and timer

  // state
  dpr_code_type    in_q  [8];   // input registers
  dpr_code_type    dac_q [8];   // dac registers
  dpr_mask_type    pd_q;        // per-channel power-down flag
  dpr_mask_type    pd_d;        // next power-down flags
  dpr_ref_src_type ref_src_q;   // reference state and its cause
  dpr_ref_src_type ref_src_d;   // next reference state
  logic            ref_ext_q;   // external reference mode
  logic            ref_ext_d;   // next mode
  logic            ref_on_q;    // internal reference running
  logic            bias_q;      // main bias running
  logic            ld_q;        // last load pin level
  logic            ack_q;       // bus answer
  logic [31:0]     rd_q;        // registered read data
  logic [31:0]     rd_d;        // read mux
  // decoded command word
  logic [3:0]      wcmd;        // command nibble
  logic [3:0]      waddr;       // channel address nibble
  logic [15:0]     wdata;       // data word
  dpr_mask_type    ch_mask;     // channels the address selects
  dpr_mask_type    wr_mask;     // channels whose input is written
  dpr_mask_type    upd_mask;    // channels updated
  dpr_mask_type    wake;        // powered-down channels now updated
  logic            ld_fall;     // load pin falling edge
  logic            wr_fire;     // bus write takes effect
  logic [127:0]    in_flat;     // input registers, flat

  // command word fields
  assign wcmd  = lnk.word[23:20];  // [R01]
  assign waddr = lnk.word[19:16];  // [R01]
  assign wdata = lnk.word[15:0];   // [R01]

  // address nibble to channel mask; all-channel code selects eight
  always_comb begin
    ch_mask = '0;
    if (waddr == `DPR_ADDR_ALL) begin
      ch_mask = '1;
    end else if (!waddr[3]) begin
      ch_mask[waddr[2:0]] = 1'b1;
    end
  end

  // load pin is synchronous; falling edge updates every channel
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ld_q <= 1'b1;
    end else begin
      ld_q <= async_load_pin_n;
    end
  end
  assign ld_fall = ld_q && !async_load_pin_n;

  // command decode and power / reference next state
  always_comb begin
    pd_d      = pd_q;
    ref_src_d = ref_src_q;
    ref_ext_d = ref_ext_q;
    wr_mask   = '0;
    upd_mask  = '0;
    if (ld_fall) begin
      upd_mask = '1;  // [R08]
    end
    if (lnk.word_valid) begin
      unique case (wcmd)
        `DPR_CMD_WR_IN: begin
          wr_mask = ch_mask;
        end
        `DPR_CMD_UPD: begin
          upd_mask = upd_mask | ch_mask;  // [R08]
        end
        `DPR_CMD_WR_UPDA: begin
          wr_mask  = ch_mask;
          upd_mask = '1;  // [R08]
        end
        `DPR_CMD_WR_UPD: begin
          wr_mask  = ch_mask;
          upd_mask = upd_mask | ch_mask;  // [R08]
        end
        `DPR_CMD_PD: begin
          pd_d = pd_q | ch_mask;  // [R03] [R06]
        end
        `DPR_CMD_PD_CHIP: begin
          pd_d = '1;  // [R04] [R06]
          if (ref_src_q == REF_ON) begin
            ref_src_d = REF_OFF_CHIP;  // [R04] [R15]
          end
        end
        `DPR_CMD_INT_REF: begin
          ref_ext_d = 1'b0;    // [R13]
          ref_src_d = REF_ON;  // [R11] [R12]
        end
        `DPR_CMD_EXT_REF: begin
          ref_ext_d = 1'b1;         // [R05]
          ref_src_d = REF_OFF_EXT;  // [R05] [R15]
        end
        default: begin
          // no-op and reserved codes change nothing
        end
      endcase
    end
    wake = upd_mask & pd_q;
    pd_d = pd_d & ~upd_mask;  // [R08]
    // a channel waking restores a reference the chip command stopped
    if (wake != '0 && ref_src_d == REF_OFF_CHIP) begin
      ref_src_d = REF_ON;  // [R12]
    end
  end

  // power-down flags, reference state, bias
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pd_q      <= '0;
      ref_src_q <= REF_ON;  // [R13]
      ref_ext_q <= 1'b0;    // [R13]
      ref_on_q  <= 1'b1;
      bias_q    <= 1'b1;
    end else begin
      pd_q      <= pd_d;       // [R15]
      ref_src_q <= ref_src_d;  // [R15]
      ref_ext_q <= ref_ext_d;
      ref_on_q  <= (ref_src_d == REF_ON);
      bias_q    <= !(pd_d == '1 && ref_src_d != REF_ON);  // [R10]
    end
  end

  // wake delay: long when the bias had been shut off
  assign lnk.wake_start = (wake != '0);    // [R09]
  assign lnk.wake_long  = !bias_q;         // [R10]

  // input and dac registers; power state never touches them
  generate
    for (genvar i = 0; i < 8; i++) begin : g_ch
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          in_q[i]  <= `DPR_CODE_RST;
          dac_q[i] <= `DPR_CODE_RST;
        end else begin
          if (wr_mask[i]) begin
            in_q[i] <= wdata;
          end
          if (upd_mask[i]) begin
            dac_q[i] <= wr_mask[i] ? wdata : in_q[i];  // [R07]
          end
        end
      end
      assign dac_code_o[16*i +: 16] = dac_q[i];
      assign in_flat[16*i +: 16]    = in_q[i];
    end
  endgenerate

  // wishbone: ack one cycle after request, write at the ack edge
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign lnk.byte_valid = wr_fire && wb_sel_i[0] &&
                          (wb_adr_i == `DPR_OFS_CMD);  // [R02]
  assign lnk.byte_data  = wb_dat_i[7:0];
  assign lnk.abort      = wr_fire && (wb_adr_i == `DPR_OFS_ABORT);

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == `DPR_OFS_STATUS) begin
      rd_d[`DPR_ST_PD_LSB +: 8]  = pd_q;
      rd_d[`DPR_ST_REF_EXT]      = ref_ext_q;
      rd_d[`DPR_ST_REF_ON]       = ref_on_q;
      rd_d[`DPR_ST_BIAS_ON]      = bias_q;
      rd_d[`DPR_ST_BUSY]         = lnk.wake_busy;
      rd_d[`DPR_ST_CNT_LSB +: 2] = lnk.byte_cnt;
    end else if (wb_adr_i[7:5] == 3'(`DPR_OFS_IN_BASE >> 5)) begin
      rd_d[15:0] = in_q[wb_adr_i[4:2]];
    end else if (wb_adr_i[7:5] == 3'(`DPR_OFS_DAC_BASE >> 5)) begin
      rd_d[15:0] = dac_q[wb_adr_i[4:2]];
    end
  end

  // bus answer and read data registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        rd_q <= rd_d;
      end
    end
  end

  // outputs, all from flops
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rd_q;
  assign out_hiz      = pd_q;       // [R14]
  assign int_ref_on   = ref_on_q;
  assign ref_ext_mode = ref_ext_q;
  assign bias_on      = bias_q;
  assign settle_busy  = lnk.wake_busy;

  dpr_cmd_asm u_asm (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .lnk     (lnk)
  );

  dpr_wake_tmr u_tmr (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .lnk     (lnk)
  );

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // a per-channel power-down word for any address, no load edge beside it
  sequence pd_cmd_s;
    lnk.word_valid && wcmd == `DPR_CMD_PD && !ld_fall;
  endsequence
  // a load edge with no command word in the same cycle
  sequence ld_only_s;
    ld_fall && !lnk.word_valid;
  endsequence
  // any of the four power and reference commands
  sequence ctl_cmd_s;
    lnk.word_valid && !ld_fall && wcmd[3:2] == 2'h1;
  endsequence
  // a plain update command word
  sequence upd_cmd_s;
    lnk.word_valid && wcmd == `DPR_CMD_UPD;
  endsequence
  // neither a command word nor a load edge
  sequence idle_s;
    !lnk.word_valid && !ld_fall;
  endsequence

  // unaddressed channels keep their flags
  pd_channel_a: assert property (pd_cmd_s |=>  // [R03]
    (pd_q & ~$past(ch_mask)) == ($past(pd_q) & ~$past(ch_mask)))
    else $error("power-down touched wrong channels");

  // addressed channels end up powered down
  pd_mask_a: assert property (pd_cmd_s |=>  // [R03]
    (pd_q & $past(ch_mask)) == $past(ch_mask))
    else $error("addressed channel not powered down");

  // chip command turns off channels, reference and bias
  chip_down_a: assert property (  // [R04]
    lnk.word_valid && wcmd == `DPR_CMD_PD_CHIP && !ld_fall |=>
    pd_q == '1 && !ref_on_q && !bias_on)
    else $error("chip power-down incomplete");

  // external mode always stops the internal reference
  ext_ref_a: assert property (  // [R05]
    lnk.word_valid && wcmd == `DPR_CMD_EXT_REF |=>
    ref_ext_q && !ref_on_q && ref_src_q == REF_OFF_EXT)
    else $error("external mode left reference on");

  // power commands leave input and dac registers alone
  regs_kept_a: assert property (ctl_cmd_s |=>  // [R07]
    $stable(in_flat) && $stable(dac_code_o))
    else $error("power command altered data registers");

  // load edge wakes every channel and copies the inputs
  load_wake_a: assert property (ld_only_s |=>  // [R08]
    pd_q == '0 && dac_code_o == $past(in_flat))
    else $error("load pin did not wake and update");

  // only the internal command undoes external-mode shutdown
  ext_hold_a: assert property (  // [R11]
    ref_src_q == REF_OFF_EXT &&
    !(lnk.word_valid && wcmd == `DPR_CMD_INT_REF) |=>
    ref_src_q == REF_OFF_EXT && !ref_on_q)
    else $error("external-off reference restored wrongly");

  // a command-driven wake restores a chip-stopped reference
  chip_restore_a: assert property (  // [R12]
    ref_src_q == REF_OFF_CHIP && wake != '0 && !ld_fall |=>
    ref_on_q ##1 ref_on_q)
    else $error("waking channel did not restore reference");

  // any wake starts the settle delay
  wake_sel_a: assert property (  // [R10]
    wake != '0 |=> settle_busy && (bias_on || pd_q != '1) )
    else $error("wake delay not started");

  // internal command brings back internal mode and the reference
  int_ref_a: assert property (  // [R13]
    lnk.word_valid && wcmd == `DPR_CMD_INT_REF |=> !ref_ext_q && ref_on_q)
    else $error("internal reference not selected");

  // nothing moves without a full word or a load edge
  idle_hold_a: assert property (idle_s |=>  // [R02]
    $stable(pd_q) && $stable(ref_src_q) && $stable(ref_ext_q) &&
    $stable(in_flat) && $stable(dac_code_o))
    else $error("state changed with no command");

  // bias is off exactly when all channels and the reference are
  bias_track_a: assert property (  // [R10]
    bias_on == !(pd_q == '1 && !ref_on_q))
    else $error("bias state disagrees with power state");

  // a short wake keeps the busy flag up for a good while
  wake_short_a: assert property (  // [R09]
    wake != '0 && bias_on |=> settle_busy [*8])
    else $error("short wake delay cut off");

  // an update command leaves its channels powered up
  upd_wake_a: assert property (upd_cmd_s |=>  // [R08]
    (pd_q & $past(ch_mask)) == '0)
    else $error("updated channel still powered down");
endmodule
`default_nettype wire

// >>> design/dpr_cfg.svh
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
// register byte offsets on the wishbone port
`define DPR_OFS_CMD      8'h00
`define DPR_OFS_ABORT    8'h04
`define DPR_OFS_STATUS   8'h08
`define DPR_OFS_IN_BASE  8'h40
`define DPR_OFS_DAC_BASE 8'h60
// status field positions
`define DPR_ST_PD_LSB    0
`define DPR_ST_REF_EXT   8
`define DPR_ST_REF_ON    9
`define DPR_ST_BIAS_ON   10
`define DPR_ST_BUSY      11
`define DPR_ST_CNT_LSB   16
// command codes (upper nibble of the first byte)
`define DPR_CMD_WR_IN    4'h0
`define DPR_CMD_UPD      4'h1
`define DPR_CMD_WR_UPDA  4'h2
`define DPR_CMD_WR_UPD   4'h3
`define DPR_CMD_PD       4'h4
`define DPR_CMD_PD_CHIP  4'h5
`define DPR_CMD_INT_REF  4'h6
`define DPR_CMD_EXT_REF  4'h7
`define DPR_CMD_NOP      4'hf
`define DPR_ADDR_ALL     4'hf
// reset value of input and dac registers
`define DPR_CODE_RST     16'h0000
// timing
`define DPR_CLK_NS       50
`define DPR_WAKE_NS      12000
`define DPR_WAKE_BIAS_NS 14000
`define DPR_WAKE_CYC ((`DPR_WAKE_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_WAKE_BIAS_CYC \
  ((`DPR_WAKE_BIAS_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`endif

// >>> design/dpr_pkg.sv
package dpr_pkg;
  // one bit per channel
  typedef logic [7:0] dpr_mask_type;
  // one 16-bit channel code
  typedef logic [15:0] dpr_code_type;
  // which command, if any, turned the internal reference off
  typedef enum logic [1:0] {
    REF_ON,
    REF_OFF_CHIP,
    REF_OFF_EXT
  } dpr_ref_src_type;
endpackage

// >>> design/dpr_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dpr_link_if;
  logic [7:0]  byte_data;   // command byte from the bus
  logic        byte_valid;  // one-cycle byte strobe
  logic        abort;       // drop a partial word
  logic        word_valid;  // one-cycle complete word strobe
  logic [23:0] word;        // assembled command word
  logic [1:0]  byte_cnt;    // bytes held so far
  logic        wake_start;  // start a wake-up delay
  logic        wake_long;   // bias was off, use the long delay
  logic        wake_busy;   // delay running
  modport asm_mp  (input byte_data, byte_valid, abort,
                   output word_valid, word, byte_cnt);
  modport tmr_mp  (input wake_start, wake_long, output wake_busy);
  modport core_mp (output byte_data, byte_valid, abort, wake_start,
                   wake_long,
                   input word_valid, word, byte_cnt, wake_busy);
endinterface
`default_nettype wire

// >>> design/dpr_cmd_asm.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_cmd_asm (
  input  wire logic ref_clk,        // system clock
  input  wire logic nrst,           // async reset, active low
  dpr_link_if.asm_mp lnk            // byte in, word out
);
  import dpr_pkg::*;
  logic [15:0] hold_q;  // first two bytes
  logic [1:0]  cnt_q;   // bytes held

  // gather three bytes, fire the word on the third
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q         <= 16'h0000;
      cnt_q          <= 2'h0;
      lnk.word_valid <= 1'b0;
      lnk.word       <= 24'h00_0000;
    end else begin
      lnk.word_valid <= 1'b0;
      if (lnk.abort) begin
        cnt_q <= 2'h0;  // partial word dropped
      end else if (lnk.byte_valid) begin
        if (cnt_q == 2'h2) begin
          lnk.word_valid <= 1'b1;  // [R02]
          lnk.word       <= {hold_q, lnk.byte_data};  // [R01]
          cnt_q          <= 2'h0;
        end else begin
          hold_q <= {hold_q[7:0], lnk.byte_data};
          cnt_q  <= cnt_q + 2'h1;
        end
      end
    end
  end
  assign lnk.byte_cnt = cnt_q;

  cmd_exec_a: assert property (@(posedge ref_clk) disable iff (!nrst)  // [R02]
    lnk.word_valid |-> $past(cnt_q) == 2'h2 && $past(lnk.byte_valid))
    else $error("word fired before three bytes");
endmodule
`default_nettype wire

// >>> design/dpr_wake_tmr.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpr_cfg.svh"
module dpr_wake_tmr #(
  parameter int SHORT_CYC = `DPR_WAKE_CYC,      // channel wake cycles
  parameter int LONG_CYC  = `DPR_WAKE_BIAS_CYC  // bias wake cycles
) (
  input  wire logic ref_clk,        // system clock
  input  wire logic nrst,           // async reset, active low
  dpr_link_if.tmr_mp lnk            // start in, busy out
);
  import dpr_pkg::*;
  localparam int CW = $clog2(LONG_CYC + 1);  // counter width
  generate
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad
      $error("wake counts out of range");
    end
  endgenerate
  logic [CW-1:0] cnt_q;  // cycles left
  logic          busy_q; // delay running

  // load on start, count down to zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (lnk.wake_start) begin
      cnt_q  <= lnk.wake_long ? CW'(LONG_CYC) : CW'(SHORT_CYC);  // [R09] [R10]
      busy_q <= 1'b1;
    end else begin
      if (cnt_q != '0) cnt_q <= cnt_q - CW'(1);
      busy_q <= (cnt_q > CW'(1));
    end
  end
  assign lnk.wake_busy = busy_q;

  short_load_a: assert property (  // [R09]
    @(posedge ref_clk) disable iff (!nrst)
    lnk.wake_start && !lnk.wake_long |=> cnt_q == CW'(SHORT_CYC))
    else $error("short wake delay not loaded");
  long_load_a: assert property (  // [R10]
    @(posedge ref_clk) disable iff (!nrst)
    lnk.wake_start && lnk.wake_long |=> cnt_q == CW'(LONG_CYC) && busy_q)
    else $error("long wake delay not loaded");
  busy_end_a: assert property (@(posedge ref_clk) disable iff (!nrst)  // [R09]
    cnt_q == CW'(1) && !lnk.wake_start |=> !busy_q && cnt_q == '0)
    else $error("busy outlives the delay");
endmodule
`default_nettype wire

// >>> bench/dpr_master.sv
`timescale 1ns/100ps
`default_nettype none
// far-side command master, speaking classic single wishbone cycles
module dpr_master (
  input  wire logic        ref_clk, // system clock
  output logic             cyc,     // bus cycle
  output logic             stb,     // strobe
  output logic             we,      // write enable
  output logic [7:0]       adr,     // byte address
  output logic [3:0]       sel,     // byte lanes
  output logic [31:0]      dat,     // write data
  input  wire logic [31:0] rdat,    // read data
  input  wire logic        ack      // acknowledge
);
  // bus idle from time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  // one cycle: request held until ack is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    // released data must not keep showing the last value
    dat <= ~d;
  endtask

  // whole command word: code and channel, then data msb and lsb
  task automatic cmd(input logic [3:0] c, input logic [3:0] ch,
                     input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, 8'h00, {24'h00_0000, c, ch}, q);
    xfer(1'b1, 8'h00, {24'h00_0000, d[15:8]}, q);
    xfer(1'b1, 8'h00, {24'h00_0000, d[7:0]}, q);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_dac_powerdown_refmode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dac_powerdown_refmode_ctrl;
  import dpr_pkg::*;
  logic         ref_clk;   // 20 MHz clock
  logic         nrst;      // reset, active low
  logic         load_n;    // load pin, active low
  logic         cyc;       // bus cycle
  logic         stb;       // strobe
  logic         we;        // write enable
  logic [7:0]   adr;       // address
  logic [3:0]   sel;       // lanes
  logic [31:0]  wdat;      // write data
  logic [31:0]  rdat;      // read data
  logic         ack;       // acknowledge
  logic [127:0] codes;     // dac codes
  dpr_mask_type hiz;       // per-channel power-down
  logic         ref_on;    // internal reference running
  logic         ext;       // external reference mode
  logic         bias;      // main bias running
  logic         busy;      // wake delay running
  logic [31:0]  q;         // read result
  int           w;         // measured wake length
  int           bad_count = 0;
  int           n_tests   = 0;
  int           cyc_cnt   = 0;

  dpr_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .async_load_pin_n(load_n), .dac_code_o(codes), .out_hiz(hiz),
    .int_ref_on(ref_on), .ref_ext_mode(ext), .bias_on(bias),
    .settle_busy(busy));
  dpr_master mst (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));

  // free-running clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard: far above the roughly 1300 cycles the tests need
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // compare seen against expected, counting every comparison
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // status word: bytes held, {busy,bias,ref on,ext}, flags
  function automatic logic [31:0] stat(input logic [7:0] pd,
                                       input logic [3:0] f,
                                       input logic [1:0] n);
    return {14'h0000, n, 4'h0, f, pd};
  endfunction

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    mst.xfer(1'b0, a, 32'h0000_0000, d);
  endtask

  // state lands two edges after the word, so a few cycles suffice
  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask

  // count the cycles the wake delay stays high, bounded
  task automatic wake_len(output int n);
    n = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge ref_clk);
      if (busy === 1'b1) n++;
      else if (n > 0) break;
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    nrst   = 1'b0;
    load_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    // reset state: internal reference, all channels up
    rd(8'h08, q);
    check("status", q, stat(8'h00, 4'h6, 2'h0));
    $display("test reset done");
    // write then update channel 2; a partial word does nothing
    mst.cmd(4'h0, 4'h2, 16'h1234);
    mst.cmd(4'h1, 4'h2, 16'h0000);
    settle();
    check("dac2", {16'h0000, codes[47:32]}, 32'h0000_1234);
    mst.xfer(1'b1, 8'h00, {24'h00_0000, 4'h4, 4'h2}, q);
    mst.xfer(1'b1, 8'h00, 32'h0000_00ab, q);
    settle();
    rd(8'h08, q);
    check("partial", q, stat(8'h00, 4'h6, 2'h2));
    mst.xfer(1'b1, 8'h04, 32'h0000_0000, q);
    rd(8'h08, q);
    check("abort", q, stat(8'h00, 4'h6, 2'h0));
    // write channel 3 and update all; a no-op changes nothing
    mst.cmd(4'h2, 4'h3, 16'h7777);
    mst.cmd(4'hf, 4'hf, 16'hffff);
    settle();
    rd(8'h6c, q);
    check("dac3", q, 32'h0000_7777);
    check("dac2all", {16'h0000, codes[47:32]}, 32'h0000_1234);
    rd(8'h08, q);
    check("nop", q, stat(8'h00, 4'h6, 2'h0));
    $display("test word done");
    // power down channel 2 only; registers and data word untouched
    mst.cmd(4'h4, 4'h2, 16'habcd);
    settle();
    check("hiz", {24'h00_0000, hiz}, 32'h0000_0004);
    rd(8'h48, q);
    check("in2", q, 32'h0000_1234);
    rd(8'h68, q);
    check("dac2pd", q, 32'h0000_1234);
    // update wakes it, others were up so the short delay
    mst.cmd(4'h1, 4'h2, 16'h0000);
    wake_len(w);
    check("wake", 32'(w), 32'h0000_00f0);
    check("hiz", {24'h00_0000, hiz}, 32'h0000_0000);
    $display("test channel done");
    // chip power-down, then the load pin wakes everything
    mst.cmd(4'h5, 4'h0, 16'hffff);
    settle();
    rd(8'h08, q);
    check("chip", q, stat(8'hff, 4'h0, 2'h0));
    check("biasoff", {30'h0000_0000, bias, ref_on}, 32'h0000_0000);
    @(posedge ref_clk);
    load_n <= 1'b0;
    @(posedge ref_clk);
    load_n <= 1'b1;
    wake_len(w);
    check("wake", 32'(w), 32'h0000_0118);
    rd(8'h08, q);
    check("woke", q, stat(8'h00, 4'h6, 2'h0));
    check("biason", {31'h0000_0000, bias}, 32'h0000_0001);
    $display("test chip done");
    // external mode: only the internal command restores the ref
    mst.cmd(4'h7, 4'h0, 16'h0000);
    settle();
    check("ext", {30'h0000_0000, ext, ref_on}, 32'h0000_0002);
    mst.cmd(4'h4, 4'h0, 16'h0000);
    mst.cmd(4'h4, 4'h7, 16'h0000);
    settle();
    check("hiz", {24'h00_0000, hiz}, 32'h0000_0081);
    mst.cmd(4'h1, 4'hf, 16'h0000);
    wake_len(w);
    check("wake", 32'(w), 32'h0000_00f0);
    check("refx", {30'h0000_0000, ext, ref_on}, 32'h0000_0002);
    mst.cmd(4'h6, 4'h0, 16'h0000);
    settle();
    check("int", {30'h0000_0000, ext, ref_on}, 32'h0000_0001);
    $display("test reference done");
    // chip power-down, then a write-and-update of one channel wakes it and the reference
    mst.cmd(4'h5, 4'h0, 16'h0000);
    settle();
    mst.cmd(4'h3, 4'h1, 16'h5555);
    wake_len(w);
    check("wake", 32'(w), 32'h0000_0118);
    rd(8'h08, q);
    check("ch1", q, stat(8'hfd, 4'h6, 2'h0));
    rd(8'h64, q);
    check("dac1", q, 32'h0000_5555);
    rd(8'h30, q);
    check("unmapped", q, 32'h0000_0000);
    $display("test restore done");
    end_of_test();
  end
endmodule
`default_nettype wire
